// ### src/pdcl_top.sv
// Start-up phase detection, over-current trip and max-current register
`timescale 1ns/1ps
`default_nettype none
module pdcl_top #(
  parameter int unsigned NPH = pdcl_pkg::MAX_PHASES
) (
  input  wire logic                   core_clk_in,       // 50 MHz clock
  input  wire logic                   rstn_in,           // async reset, low
  input  wire logic                   enable_in,         // controller enable
  input  wire logic [NPH-2:0]         sense_tied_in,     // pins 2..4 > 4.5 V
  output logic      [NPH-2:0]         sense_sink_out,    // test current on
  input  wire logic                   limit_nominal_in,  // sink > 10 uA
  input  wire logic                   limit_severe_in,   // sink > 15 uA
  input  wire logic                   ramp_supply_ok_in, // ramp supply > 4 V
  input  wire logic [NPH-1:0]         pwm_cmp_in,        // per-phase compare
  output pdcl_pkg::pdcl_pwm_type      pwm_out [NPH],     // modulator outputs
  output logic [pdcl_pkg::RAMP_W-1:0] ramp_phase_out [NPH], // ramp offsets
  input  wire logic                   driver_on_in,      // driver-on level
  output logic                        driver_on_out,     // driver-on drive
  output logic                        driver_on_oe_out,  // driver-on enable
  output logic [pdcl_pkg::PH_CODE_W-1:0] phase_count_out, // active phases
  output logic                        oc_fault_out,      // latched trip
  output logic                        undervoltage_lockout_out,          // ramp lockout
  output logic                        adc_start_out,     // start conversion
  output pdcl_pkg::pdcl_adc_chan_type adc_chan_out,      // channel select
  input  wire logic                   adc_done_in,       // result ready
  input  wire logic [7:0]             adc_data_in,       // result code
  output logic [7:0]                  current_mon_out,   // monitor code
  output logic [7:0]                  temperature_out,   // temperature code
  input  wire logic                   reg_rd_in,         // register read
  input  wire logic [7:0]             reg_addr_in,       // register offset
  output logic [7:0]                  reg_rdata_out      // read data
);

  localparam int unsigned PW = pdcl_pkg::PH_CODE_W;
  localparam int unsigned RW = pdcl_pkg::RAMP_W;

  // Reset release through two flops
  logic rst_sync1_q;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_q <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n       <= rst_sync1_q;
    end
  end

  pdcl_pkg::pdcl_state_type state_q, state_d;
  logic [PW-1:0]  nph_q, nph_d;
  logic [NPH-1:0] active_q, active_d;
  logic [NPH-1:0] fired_q, fired_d;
  logic           fault_q, fault_d;
  logic           en_q, en_d;
  logic [7:0]     max_cur_q, max_cur_d;
  logic [7:0]     rdata_q, rdata_d;
  logic           detect_done;
  logic           oc_qual_done;
  logic           oc_watch;
  logic           enabled;
  logic           undervoltage_lockout;
  logic           max_load_req;
  logic [7:0]     max_load_code;
  logic           max_load_valid;
  logic [NPH-1:0] tied_all;

  assign enabled  = enable_in;
  assign tied_all = {sense_tied_in, 1'b0};
  assign undervoltage_lockout     = enabled && !ramp_supply_ok_in;
  assign oc_watch = (state_q == pdcl_pkg::ST_RUN) ||
                    (state_q == pdcl_pkg::ST_HOLD);
  assign max_load_req = enabled && !en_q;

  pdcl_qual_timer #(
    .WIDTH (pdcl_pkg::TMR_W),
    .LIMIT (pdcl_pkg::TMR_W'(pdcl_pkg::DETECT_CYC))
  ) u_detect_timer (
    .clk_in   (core_clk_in),
    .rstn_in  (rst_n),
    .run_in   (state_q == pdcl_pkg::ST_DETECT),
    .done_out (detect_done)
  );

  pdcl_qual_timer #(
    .WIDTH (pdcl_pkg::TMR_W),
    .LIMIT (pdcl_pkg::TMR_W'(pdcl_pkg::OC_QUAL_CYC))
  ) u_oc_timer (
    .clk_in   (core_clk_in),
    .rstn_in  (rst_n),
    .run_in   (oc_watch && limit_nominal_in),
    .done_out (oc_qual_done)
  );

  pdcl_adc_seq #(
    .PERIOD (pdcl_pkg::ADC_PERIOD_CYC)
  ) u_adc_seq (
    .clk_in             (core_clk_in),
    .rstn_in            (rst_n),
    .active_in          (enabled),
    .max_load_req_in    (max_load_req),
    .adc_done_in        (adc_done_in),
    .adc_data_in        (adc_data_in),
    .adc_start_out      (adc_start_out),
    .adc_chan_out       (adc_chan_out),
    .max_load_code_out  (max_load_code),
    .max_load_valid_out (max_load_valid),
    .current_mon_out    (current_mon_out),
    .temperature_out    (temperature_out)
  );

  // Sequence, phase configuration and fault latch
  always_comb begin
    state_d  = state_q;
    nph_d    = nph_q;
    active_d = active_q;
    fired_d  = fired_q;
    fault_d  = fault_q;
    en_d     = enabled;
    if (!enabled) begin
      state_d = pdcl_pkg::ST_OFF;
      fault_d = 1'b0;
      fired_d = '0;
    end else begin
      case (state_q)
        pdcl_pkg::ST_OFF: begin
          state_d = pdcl_pkg::ST_DETECT;
        end
        pdcl_pkg::ST_DETECT: begin
          if (detect_done) begin
            state_d = pdcl_pkg::ST_MID;
            // Pins 4 / 4,2 / 4,3,2 tied reduce the count
            if (sense_tied_in == 3'b111) begin
              nph_d    = PW'(1);
              active_d = 4'b0001;
            end else if (sense_tied_in == 3'b101) begin
              nph_d    = PW'(2);
              active_d = 4'b0011;
            end else if (sense_tied_in[2]) begin
              nph_d    = PW'(3);
              active_d = 4'b0111;
            end else begin
              nph_d    = PW'(4);
              active_d = 4'b1111;
            end
          end
        end
        pdcl_pkg::ST_MID: begin
          state_d = pdcl_pkg::ST_HOLD;
        end
        pdcl_pkg::ST_HOLD: begin
          if (driver_on_in && !undervoltage_lockout) begin
            state_d = pdcl_pkg::ST_RUN;
          end
        end
        pdcl_pkg::ST_RUN: begin
          fired_d = fired_q | pwm_cmp_in;
          if (undervoltage_lockout || !driver_on_in) begin
            state_d = pdcl_pkg::ST_MID;
            fired_d = '0;
          end
        end
        default: begin
          state_d = pdcl_pkg::ST_FAULT;
        end
      endcase
      if (oc_watch && (limit_severe_in || oc_qual_done)) begin
        state_d = pdcl_pkg::ST_FAULT;
        fault_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= pdcl_pkg::ST_OFF;
      nph_q    <= PW'(pdcl_pkg::MAX_PHASES);
      active_q <= '1;
      fired_q  <= '0;
      fault_q  <= 1'b0;
      en_q     <= 1'b0;
    end else begin
      state_q  <= state_d;
      nph_q    <= nph_d;
      active_q <= active_d;
      fired_q  <= fired_d;
      fault_q  <= fault_d;
      en_q     <= en_d;
    end
  end

  // Platform max-current register and read port
  always_comb begin
    max_cur_d = max_cur_q;
    rdata_d   = rdata_q;
    if (max_load_valid) begin
      max_cur_d = max_load_code;
    end
    if (reg_rd_in) begin
      if (reg_addr_in == pdcl_pkg::REG_PLATFORM_MAX_CURRENT) begin
        rdata_d = max_cur_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      max_cur_q <= pdcl_pkg::PLATFORM_MAX_CURRENT_RST;
      rdata_q   <= 8'h00;
    end else begin
      max_cur_q <= max_cur_d;
      rdata_q   <= rdata_d;
    end
  end

  // Per-phase modulator outputs and ramp offsets
  genvar gi;
  generate
    for (gi = 0; gi < NPH; gi++) begin : g_phase
      pdcl_pkg::pdcl_pwm_type pwm_d;
      pdcl_pkg::pdcl_pwm_type pwm_q;
      logic [RW-1:0]          ramp_d;
      logic [RW-1:0]          ramp_q;

      always_comb begin
        pwm_d  = '{oe: 1'b1, mid: 1'b1, level: 1'b0};
        ramp_d = RW'((gi * 256) / nph_q);
        case (state_q)
          pdcl_pkg::ST_DETECT: begin
            // Phase one low, the rest open for the
            pwm_d = '{oe: (gi == 0), mid: 1'b0, level: 1'b0};
          end
          pdcl_pkg::ST_MID, pdcl_pkg::ST_HOLD: begin
            pwm_d.oe = active_q[gi];
          end
          pdcl_pkg::ST_RUN: begin
            pwm_d.oe    = active_q[gi];
            pwm_d.mid   = !(fired_q[gi] || pwm_cmp_in[gi]);
            pwm_d.level = pwm_cmp_in[gi];
          end
          pdcl_pkg::ST_FAULT: begin
            pwm_d = '{oe: active_q[gi], mid: 1'b0, level: 1'b0};
          end
          default: begin
            pwm_d.oe = !tied_all[gi] || en_q;
          end
        endcase
        if (gi >= nph_q) begin
          ramp_d = '0;
        end
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          pwm_q  <= '{oe: 1'b0, mid: 1'b0, level: 1'b0};
          ramp_q <= '0;
        end else begin
          pwm_q  <= pwm_d;
          ramp_q <= ramp_d;
        end
      end

      assign pwm_out[gi]        = pwm_q;
      assign ramp_phase_out[gi] = ramp_q;
    end
  endgenerate

  // Test sink only during detection
  assign sense_sink_out   = {(NPH-1){state_q == pdcl_pkg::ST_DETECT}};
  // Driver-on is driven high only once outputs sit at mid
  assign driver_on_out    = (state_q == pdcl_pkg::ST_HOLD) ||
                            (state_q == pdcl_pkg::ST_RUN);
  assign driver_on_oe_out = 1'b1;
  assign phase_count_out  = nph_q;
  assign oc_fault_out     = fault_q;
  assign undervoltage_lockout_out         = undervoltage_lockout;
  assign reg_rdata_out    = rdata_q;

endmodule : pdcl_top
`default_nettype wire

// ### src/pdcl_pkg.sv
// Shared constants and types for the phase detect and current limit block
package pdcl_pkg;

  // Core clock
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;

  // Phase detection interval
  localparam int unsigned DETECT_US      = 30;
  localparam int unsigned DETECT_CYC     = DETECT_US * CYC_PER_US;

  // Qualification time of the nominal over-current trip
  localparam int unsigned OC_QUAL_US     = 50;
  localparam int unsigned OC_QUAL_CYC    = OC_QUAL_US * CYC_PER_US;

  // Spacing of periodic monitor and temperature conversions
  localparam int unsigned ADC_PERIOD_CYC = 500;

  // Timer counter width, wide enough for the longest interval
  localparam int unsigned TMR_W          = 12;

  // Register map and reset value
  localparam logic [7:0]  REG_PLATFORM_MAX_CURRENT = 8'h21;
  localparam logic [7:0]  PLATFORM_MAX_CURRENT_RST = 8'h00;

  // Phase count and ramp spacing
  localparam int unsigned MAX_PHASES     = 4;
  localparam int unsigned PH_CODE_W      = 3;
  localparam int unsigned RAMP_W         = 8;

  // Converter channels
  typedef enum logic [1:0] {
    ADC_MAX_LOAD,
    ADC_CURRENT_MON,
    ADC_TEMPERATURE
  } pdcl_adc_chan_type;

  // One modulator output: oe high drives, mid selects the mid level
  typedef struct packed {
    logic oe;
    logic mid;
    logic level;
  } pdcl_pwm_type;

  // Start-up and protection sequence
  typedef enum logic [2:0] {
    ST_OFF,
    ST_DETECT,
    ST_MID,
    ST_HOLD,
    ST_RUN,
    ST_FAULT
  } pdcl_state_type;

endpackage : pdcl_pkg

// ### src/pdcl_qual_timer.sv
// Qualification timer that restarts whenever its condition drops
`timescale 1ns/1ps
`default_nettype none
module pdcl_qual_timer #(
  parameter int unsigned            WIDTH = pdcl_pkg::TMR_W,
  parameter logic [WIDTH-1:0]       LIMIT = WIDTH'(pdcl_pkg::DETECT_CYC)
) (
  input  wire logic clk_in,  // core clock
  input  wire logic rstn_in, // synchronised reset, active low
  input  wire logic run_in,  // condition to be timed
  output logic      done_out // high once run_in has held LIMIT cycles
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             at_end;

  assign at_end   = (cnt_q == LIMIT - WIDTH'(1));
  assign done_out = run_in && at_end;

  always_comb begin
    if (!run_in) begin
      cnt_d = '0;
    end else if (at_end) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pdcl_qual_timer
`default_nettype wire

// ### src/pdcl_adc_seq.sv
// Converter sequencer for the max-load, monitor and temperature inputs
`timescale 1ns/1ps
`default_nettype none
module pdcl_adc_seq #(
  parameter int unsigned PERIOD = pdcl_pkg::ADC_PERIOD_CYC
) (
  input  wire logic                        clk_in,             // core clock
  input  wire logic                        rstn_in,            // reset, low
  input  wire logic                        active_in,          // enabled
  input  wire logic                        max_load_req_in,    // pulse
  input  wire logic                        adc_done_in,        // result
  input  wire logic [7:0]                  adc_data_in,        // 2 V = ff
  output logic                             adc_start_out,      // pulse
  output pdcl_pkg::pdcl_adc_chan_type      adc_chan_out,       // channel
  output logic [7:0]                       max_load_code_out,  // 1 A/LSB
  output logic                             max_load_valid_out, // pulse
  output logic [7:0]                       current_mon_out,    // monitor
  output logic [7:0]                       temperature_out     // temp
);

  localparam int unsigned TW = $clog2(PERIOD + 1);

  logic                        pend_q, pend_d;
  logic                        busy_q, busy_d;
  logic                        due_q, due_d;
  logic                        next_temp_q, next_temp_d;
  logic [TW-1:0]               tick_q, tick_d;
  pdcl_pkg::pdcl_adc_chan_type chan_q, chan_d;
  logic [7:0]                  mon_q, mon_d;
  logic [7:0]                  temp_q, temp_d;
  logic [7:0]                  max_q, max_d;
  logic                        maxv_q, maxv_d;
  logic                        start;

  assign start = !busy_q && (pend_q || (active_in && due_q));

  always_comb begin
    pend_d      = pend_q;
    busy_d      = busy_q;
    due_d       = due_q;
    next_temp_d = next_temp_q;
    tick_d      = tick_q;
    chan_d      = chan_q;
    mon_d       = mon_q;
    temp_d      = temp_q;
    max_d       = max_q;
    maxv_d      = 1'b0;
    if (start) begin
      busy_d = 1'b1;
      if (pend_q) begin
        chan_d = pdcl_pkg::ADC_MAX_LOAD;
        pend_d = 1'b0;
      end else begin
        due_d       = 1'b0;
        next_temp_d = !next_temp_q;
        chan_d      = next_temp_q ? pdcl_pkg::ADC_TEMPERATURE
                                  : pdcl_pkg::ADC_CURRENT_MON;
      end
    end
    // Tick after start so a period falling on a start is kept
    if (tick_q == TW'(PERIOD - 1)) begin
      tick_d = '0;
      due_d  = 1'b1;
    end else begin
      tick_d = tick_q + TW'(1);
    end
    if (max_load_req_in) begin
      pend_d = 1'b1;
    end
    if (busy_q && adc_done_in) begin
      busy_d = 1'b0;
      case (chan_q)
        pdcl_pkg::ADC_MAX_LOAD: begin
          max_d  = adc_data_in;
          maxv_d = 1'b1;
        end
        pdcl_pkg::ADC_CURRENT_MON: mon_d  = adc_data_in;
        default:                   temp_d = adc_data_in;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_q      <= 1'b0;
      busy_q      <= 1'b0;
      due_q       <= 1'b0;
      next_temp_q <= 1'b0;
      tick_q      <= '0;
      chan_q      <= pdcl_pkg::ADC_CURRENT_MON;
      mon_q       <= 8'h00;
      temp_q      <= 8'h00;
      max_q       <= 8'h00;
      maxv_q      <= 1'b0;
    end else begin
      pend_q      <= pend_d;
      busy_q      <= busy_d;
      due_q       <= due_d;
      next_temp_q <= next_temp_d;
      tick_q      <= tick_d;
      chan_q      <= chan_d;
      mon_q       <= mon_d;
      temp_q      <= temp_d;
      max_q       <= max_d;
      maxv_q      <= maxv_d;
    end
  end

  assign adc_start_out      = start;
  assign adc_chan_out       = start ? (pend_q ? pdcl_pkg::ADC_MAX_LOAD
                                              : chan_d) : chan_q;
  assign max_load_code_out  = max_q;
  assign max_load_valid_out = maxv_q;
  assign current_mon_out    = mon_q;
  assign temperature_out    = temp_q;

endmodule : pdcl_adc_seq
`default_nettype wire

// ### verification/pdcl_far_side.sv
// Gate driver and converter front end facing the controller
`timescale 1ns/1ps
`default_nettype none
module pdcl_far_side #(
  parameter int HOLD = 40
) (
  input  wire logic                        clk_in,  // core clock
  input  wire logic                        sup_in,  // driver supply good
  input  wire logic                        drv_in,  // controller level
  input  wire logic                        oe_in,   // controller enable
  output logic                             line_out, // resolved line
  input  wire logic                        start_in, // conversion start
  input  wire pdcl_pkg::pdcl_adc_chan_type chan_in, // channel
  input  wire logic [7:0]                  code_in, // base code
  input  wire logic [3:0]                  lat_in,  // latency
  output logic                             done_out, // result pulse
  output logic [7:0]                       data_out  // result code
);
  int                          hold_cnt = HOLD;
  int                          busy = 0;
  logic [7:0]                  last = 8'h00;
  pdcl_pkg::pdcl_adc_chan_type ch;
  initial done_out = 1'b0;
  initial data_out = 8'h00;
  // Pulled low while supply is bad and for a minimum time after
  always @(posedge clk_in) begin
    hold_cnt <= !sup_in ? HOLD : (hold_cnt > 0 ? hold_cnt - 1 : 0);
  end
  assign line_out = (hold_cnt == 0) && (oe_in ? drv_in : 1'b1);
  // Result of channel is base code plus channel number
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    data_out <= ~last;
    if (start_in) begin
      busy <= lat_in + 1;
      ch <= chan_in;
    end else if (busy > 0) begin
      busy <= busy - 1;
      if (busy == 1) begin
        done_out <= 1'b1;
        data_out <= code_in + 8'(ch);
        last <= code_in + 8'(ch);
      end
    end
  end
endmodule : pdcl_far_side
`default_nettype wire

// ### verification/pdcl_top_chk.sv
// Port assertions for the phase detect and current limit block
`timescale 1ns/1ps
`default_nettype none
module pdcl_top_chk #(
  parameter int unsigned NPH = pdcl_pkg::MAX_PHASES
) (
  input wire logic                   core_clk_in,       // clock
  input wire logic                   rstn_in,           // reset, low
  input wire logic                   enable_in,         // enable
  input wire logic [NPH-2:0]         sense_sink_out,    // test sink
  input wire logic                   limit_nominal_in,  // nominal
  input wire logic                   limit_severe_in,   // severe
  input wire logic                   ramp_supply_ok_in, // ramp ok
  input wire pdcl_pkg::pdcl_pwm_type pwm_out [NPH],     // outputs
  input wire logic                   driver_on_in,      // line
  input wire logic                   driver_on_out,     // drive
  input wire logic                   oc_fault_out,      // fault
  input wire logic                   undervoltage_lockout_out           // lockout
);
  logic [11:0] nom_q, nom_d, det_q, det_d;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Run lengths of nominal excursion and test sink
  always_comb begin
    nom_d = (limit_nominal_in && driver_on_out) ? nom_q + 12'h001 : 12'h000;
    det_d = sense_sink_out[0] ? det_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nom_q <= 12'h000;
      det_q <= 12'h000;
    end else begin
      nom_q <= nom_d;
      det_q <= det_d;
    end
  end
  property p_lock; undervoltage_lockout_out == (enable_in && !ramp_supply_ok_in); endproperty
  a_lock: assert property (p_lock) else $error("lockout wrong");
  property p_sev;
    limit_severe_in && driver_on_out && enable_in && ramp_supply_ok_in &&
      driver_on_in |=> (!enable_in or ##[0:1] oc_fault_out);
  endproperty
  a_sev: assert property (p_sev) else $error("severe no trip");
  property p_cause;
    $rose(oc_fault_out) |-> $past(limit_severe_in) ||
      $past(limit_severe_in, 2) || $past(nom_q) >= 12'h9c3;
  endproperty
  a_cause: assert property (p_cause) else $error("early trip");
  property p_hold; oc_fault_out && enable_in |=> oc_fault_out; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  property p_sink;
    sense_sink_out != '0 |-> sense_sink_out == '1 && $past(enable_in);
  endproperty
  a_sink: assert property (p_sink) else $error("sink wrong");
  property p_det;
    $fell(sense_sink_out[0]) && $past(enable_in) |->
      det_q >= 12'h5dc && det_q <= 12'h5de;
  endproperty
  a_det: assert property (p_det) else $error("detect length");
  property p_low;
    sense_sink_out[0] && $past(sense_sink_out[0]) |->
      pwm_out[0].oe && !pwm_out[0].mid && !pwm_out[0].level;
  endproperty
  a_low: assert property (p_low) else $error("phase one not low");
  property p_mid; $rose(driver_on_out) |-> pwm_out[0].mid; endproperty
  a_mid: assert property (p_mid) else $error("drive before mid");
  c_trip: cover property ($rose(oc_fault_out));
  c_driver_on: cover property ($rose(driver_on_out));
  c_det: cover property ($fell(sense_sink_out[0]));
endmodule : pdcl_top_chk
bind pdcl_top pdcl_top_chk #(.NPH(NPH)) u_chk (
  .core_clk_in, .rstn_in, .enable_in, .sense_sink_out, .limit_nominal_in,
  .limit_severe_in, .ramp_supply_ok_in, .pwm_out, .driver_on_in,
  .driver_on_out, .oc_fault_out, .undervoltage_lockout_out);
`default_nettype wire

// ### verification/pdcl_top_test.sv
// Self-checking bench for the phase detect and current limit block
`timescale 1ns/1ps
`default_nettype none
module pdcl_top_test;
  localparam int NPH = 4;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, nom = 1'b0, sev = 1'b0;
  logic ramp_ok = 1'b0, sup = 1'b0, rd = 1'b0;
  logic [2:0] tied = 3'h0, sink, ph_cnt;
  logic [3:0] cmp = 4'h0, lat = 4'h0;
  logic [7:0] addr = 8'h00, code = 8'h00, rdata, mon, temp, adc_data;
  logic driver_on, driver_on_drv, driver_on_oe, fault, undervoltage_lockout, adc_start, adc_done;
  pdcl_pkg::pdcl_adc_chan_type chan;
  pdcl_pkg::pdcl_pwm_type      pwm [NPH];
  logic [7:0]                  ramp [NPH];
  logic [7:0]                  exp_q [$];
  int fails = 0, checks_done = 0, seed = 23551;
  pdcl_top #(.NPH(NPH)) dut (
    .core_clk_in(clk), .rstn_in(rstn), .enable_in(en),
    .sense_tied_in(tied), .sense_sink_out(sink), .limit_nominal_in(nom),
    .limit_severe_in(sev), .ramp_supply_ok_in(ramp_ok), .pwm_cmp_in(cmp),
    .pwm_out(pwm), .ramp_phase_out(ramp), .driver_on_in(driver_on),
    .driver_on_out(driver_on_drv), .driver_on_oe_out(driver_on_oe),
    .phase_count_out(ph_cnt), .oc_fault_out(fault), .undervoltage_lockout_out(undervoltage_lockout),
    .adc_start_out(adc_start), .adc_chan_out(chan), .adc_done_in(adc_done),
    .adc_data_in(adc_data), .current_mon_out(mon), .temperature_out(temp),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_rdata_out(rdata));
  pdcl_far_side #(.HOLD(40)) far (
    .clk_in(clk), .sup_in(sup), .drv_in(driver_on_drv), .oe_in(driver_on_oe),
    .line_out(driver_on), .start_in(adc_start), .chan_in(chan), .code_in(code),
    .lat_in(lat), .done_out(adc_done), .data_out(adc_data));
  initial forever #10 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic sig(input int k);
    case (k)
      0: return sink[0];
      1: return driver_on_drv;
      default: return pwm[0].mid;
    endcase
  endfunction : sig
  task automatic wait_sig(input int k, input logic v);
    int n;
    n = 0;
    @(negedge clk);
    while (sig(k) !== v) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        check(8'h00, 8'h01);
        print_verdict();
      end
    end
  endtask : wait_sig
  task automatic rd_reg(input logic [7:0] a, exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rd_reg
  // Expected phase count from tied-high sense pins
  function automatic int exp_ph(input logic [2:0] t);
    if (t == 3'h7) return 1;
    if (t == 3'h5) return 2;
    return t[2] ? 3 : 4;
  endfunction : exp_ph
  task automatic bring_up(input logic [2:0] t);
    int np;
    logic [7:0] c;
    np = exp_ph(t);
    c = 8'($random(seed));
    exp_q.push_back(c);
    @(posedge clk);
    tied <= t;
    en <= 1'b1;
    code <= c;
    lat <= 4'($random(seed));
    wait_sig(0, 1'b1);
    check(sink, 3'h7);
    check(undervoltage_lockout, 1'b1);
    @(negedge clk);
    check(pwm[0], 8'h04);
    wait_sig(0, 1'b0);
    check(ph_cnt, 8'(np));
    wait_sig(1, 1'b1);
    check(driver_on_oe, 1'b1);
    for (int i = 0; i < NPH; i++) begin
      check(pwm[i].oe, 8'(i < np));
      if (i < np) check(pwm[i].mid, 1'b1);
    end
    repeat (100) @(negedge clk);
    check(driver_on, 1'b0);
    check(pwm[0].mid, 1'b1);
    @(posedge clk);
    ramp_ok <= 1'b1;
    sup <= 1'b1;
    cmp <= 4'hf;
    wait_sig(2, 1'b0);
    for (int i = 0; i < NPH; i++)
      check(ramp[i], i < np ? 8'(i * 256 / np) : 8'h00);
  endtask : bring_up
  task automatic oc_test;
    int n;
    @(posedge clk);
    nom <= 1'b1;
    repeat (2000) @(posedge clk);
    nom <= 1'b0;
    @(posedge clk);
    nom <= 1'b1;
    n = 0;
    while (fault !== 1'b1 && n < 2600) begin
      @(negedge clk);
      n++;
    end
    check(8'(n >= 2500 && n <= 2502), 8'h01);
    @(posedge clk);
    nom <= 1'b0;
    repeat (50) @(negedge clk);
    check(fault, 1'b1);
    check(pwm[0], 8'h04);
    @(posedge clk);
    en <= 1'b0;
    ramp_ok <= 1'b0;
    sup <= 1'b0;
    repeat (3) @(negedge clk);
    check(fault, 1'b0);
    bring_up(3'h0);
    rd_reg(8'h21, exp_q.pop_front());
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    repeat (2) @(negedge clk);
    check(fault, 1'b1);
    $display("over-current test done");
  endtask : oc_test
  initial begin
    logic [2:0] pats [4];
    logic [7:0] c;
    pats = '{3'h7, 3'h5, 3'h4, 3'h0};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h21, 8'h00);
    check(ph_cnt, 8'h04);
    $display("reset test done");
    foreach (pats[k]) begin
      bring_up(pats[k]);
      repeat (8) begin
        @(posedge clk);
        cmp <= 4'($random(seed));
        @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < exp_ph(pats[k]); i++)
          check(pwm[i], {6'h02, cmp[i]});
      end
      c = exp_q.pop_front();
      @(posedge clk);
      code <= ~c;
      repeat (1100) @(posedge clk);
      rd_reg(8'h33, 8'h00);
      rd_reg(8'h21, c);
      check(mon, 8'(~c + 8'h01));
      check(temp, 8'(~c + 8'h02));
      if (k == 3) oc_test();
      @(posedge clk);
      en <= 1'b0;
      ramp_ok <= 1'b0;
      sup <= 1'b0;
      repeat (3) @(negedge clk);
      check(undervoltage_lockout, 1'b0);
      check(pwm[0], 8'h06);
      $display("pattern %h done", pats[k]);
    end
    print_verdict();
  end
endmodule : pdcl_top_test
`default_nettype wire
